// File: tmr_pkg.sv
// Purpose: shared constants and types of the gated timer block
// Assumes: 8-bit registers on 32-bit Avalon-MM words
// Notes:   count bytes and control bits sit in the low byte lane
package tmr_pkg;
	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [4:0] ADDR_CTRL   = 5'h00;
	localparam logic [4:0] ADDR_GATE   = 5'h04;
	localparam logic [4:0] ADDR_OSC    = 5'h08;
	localparam logic [4:0] ADDR_CNT_LO = 5'h0C;
	localparam logic [4:0] ADDR_CNT_HI = 5'h10;
	localparam logic [4:0] ADDR_STAT   = 5'h14;
	localparam logic [4:0] ADDR_MASK   = 5'h18;

	// ==========================================================
	// field positions
	localparam int CTRL_ON      = 0;
	localparam int CTRL_PS_LSB  = 1;
	localparam int CTRL_ASYNC   = 3;
	localparam int CTRL_SRC_LSB = 4;
	localparam int GATE_MODE    = 0;
	localparam int GATE_POL     = 1;
	localparam int GATE_SEL_LSB = 2;
	localparam int OSC_EN_BIT   = 0;
	localparam int STAT_OVF     = 0;

	// ==========================================================
	// values and widths
	localparam logic [15:0] CNT_MAX  = 16'hFFFF;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [2:0]  PH_ONE   = 3'h1;
	localparam logic [1:0]  SRC_INT  = 2'h0;
	localparam logic [1:0]  SRC_EXT  = 2'h1;
	localparam logic [1:0]  SRC_OSC  = 2'h2;
	localparam logic [23:0] RD_PAD   = 24'h000000;
	localparam logic [7:0]  BYTE_Z   = 8'h00;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} bus_st_t;

	typedef struct packed {
		logic       on;
		logic [1:0] ps;
		logic       async_mode;
		logic [1:0] src;
	} tmr_ctrl_t;

	typedef struct packed {
		logic       gmode;
		logic       gate_active_level;
		logic [1:0] gsel;
	} gate_ctrl_t;

	typedef struct packed {
		logic [2:0] ph;
		logic       tick;
	} presc_st_t;

	// prescale field to phase mask: 1, 2, 4 or 8 input ticks
	function automatic logic [2:0] presc_mask(input logic [1:0] ps);
		case (ps)
			2'h0:    presc_mask = 3'h0;
			2'h1:    presc_mask = 3'h1;
			2'h2:    presc_mask = 3'h3;
			default: presc_mask = 3'h7;
		endcase
	endfunction : presc_mask
endpackage : tmr_pkg

// File: presc_div.sv
// Purpose: clock prescaler of the timer, divides source ticks
// Assumes: i_tick is a one-cycle pulse per source edge
// Notes:   phase is hidden from software, cleared by count writes
`timescale 1ns/100ps
module presc_div
	import tmr_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_clr,
	input  wire logic       i_tick,
	input  wire logic [1:0] i_ps,
	output logic            o_tick,
	output logic [2:0]      o_phase
);
	presc_st_t s_q;
	presc_st_t s_d;
	logic [2:0] mask;

	// ==========================================================
	// next state
	always_comb begin
		mask   = presc_mask(i_ps);
		s_d    = s_q;
		s_d.tick = 1'b0;
		if (i_clr) begin
			s_d.ph = '0;
		end else if (i_tick) begin
			if ((s_q.ph & mask) == mask) begin
				s_d.ph   = '0;
				s_d.tick = 1'b1;
			end else begin
				s_d.ph = s_q.ph + PH_ONE;
			end
		end
	end

	// state register
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_tick  = s_q.tick;
	assign o_phase = s_q.ph;

	// ==========================================================
	// checks
	div_out_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_tick && !i_clr && ((s_q.ph & mask) == mask)) |=> o_tick && o_phase == '0)
		else $error("prescaler missed its output tick");
	presc_clr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_clr |=> o_phase == '0 && !o_tick)
		else $error("prescaler not cleared by count write");
endmodule : presc_div

// File: gated_timer.sv
// Purpose: 16-bit gated timer with prescaler and sleep counting
// Assumes: all inputs synchronous to i_clk, Avalon-MM slave
// Notes:   every access takes one wait cycle, answer at 2nd edge
`timescale 1ns/100ps
module gated_timer
	import tmr_pkg::*;
#(
	parameter int CNT_W  = 16,
	parameter int GATE_N = 4
) (
	input  wire logic              i_clk,
	input  wire logic              i_rst_n,
	input  wire logic [4:0]        i_address,
	input  wire logic              i_read,
	input  wire logic              i_write,
	input  wire logic [31:0]       i_writedata,
	input  wire logic [3:0]        i_byteenable,
	output logic [31:0]            o_readdata,
	output logic                   o_waitrequest,
	input  wire logic              i_ext_clk_pin,
	input  wire logic              i_crystal_input_pin,
	output logic                   o_crystal_drive_pin,
	input  wire logic [GATE_N-1:0] i_gate_input_level,
	input  wire logic              i_sleep,
	output logic                   o_osc_running,
	output logic                   o_irq,
	output logic                   o_wake
);
	// ==========================================================
	// elaboration checks
	if (CNT_W != 16) begin : g_cnt_chk
		$error("count must be two bytes wide");
	end
	if (GATE_N < 1 || GATE_N > 4) begin : g_gate_chk
		$error("gate select reaches one to four sources");
	end

	typedef struct packed {
		bus_st_t    st;
		logic [7:0] rdata;
		tmr_ctrl_t  ctl;
		gate_ctrl_t gate;
		logic       osc_en;
		logic [15:0] cnt;
		logic       ovf;
		logic       msk;
		logic       raw_q;
		logic       sy1;
		logic       sy2;
		logic       sy3;
	} tmr_st_t;

	tmr_st_t s_q;
	tmr_st_t s_d;

	// gate source selector, out of range picks source zero
	function automatic logic gate_pick(input logic [GATE_N-1:0] g,
		input logic [1:0] sel);
		if (int'(sel) < GATE_N) begin
			gate_pick = g[sel];
		end else begin
			gate_pick = g[0];
		end
	endfunction : gate_pick

	logic       req;
	logic       acc;
	logic       wr_ok;
	logic       rd_ok;
	logic [7:0] wb;
	logic       src_lvl;
	logic       edge_async;
	logic       edge_sync;
	logic       src_tick;
	logic       gate_lvl;
	logic       gate_ok;
	logic       run;
	logic       presc_in;
	logic       presc_out;
	logic [2:0] presc_ph;
	logic       cnt_wr;
	logic       ovf_set;
	logic       ovf_clr;

	// ==========================================================
	// bus handshake
	assign req           = i_read | i_write;
	assign acc           = req && s_q.st == BUS_ACK;
	assign wr_ok         = acc && i_write && i_byteenable[0];
	assign rd_ok         = acc && i_read;
	assign wb            = i_writedata[7:0];
	assign o_waitrequest = req && s_q.st != BUS_ACK;
	assign o_readdata    = {RD_PAD, s_q.rdata};

	// ==========================================================
	// source edge detection
	assign src_lvl = (s_q.ctl.src == SRC_OSC) ?
		(i_crystal_input_pin & s_q.osc_en) : i_ext_clk_pin;
	assign edge_async = src_lvl & ~s_q.raw_q;
	assign edge_sync  = s_q.sy2 & ~s_q.sy3;
	// a mode change moves the edge by the sync delay
	assign src_tick = (s_q.ctl.src == SRC_INT) ? 1'b1 :
		(s_q.ctl.async_mode ? edge_async : edge_sync);

	// ==========================================================
	// gate and run qualification
	assign gate_lvl = gate_pick(i_gate_input_level, s_q.gate.gsel);
	assign gate_ok  = !s_q.gate.gmode || (gate_lvl == s_q.gate.gate_active_level);
	assign run      = s_q.ctl.on && (!i_sleep ||
		(s_q.ctl.async_mode && s_q.ctl.src == SRC_EXT));
	assign presc_in = src_tick & run & gate_ok;

	// count writes clear the prescaler phase
	assign cnt_wr = wr_ok && (i_address == ADDR_CNT_LO ||
		i_address == ADDR_CNT_HI);

	presc_div u_presc (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_clr   (cnt_wr),
		.i_tick  (presc_in),
		.i_ps    (s_q.ctl.ps),
		.o_tick  (presc_out),
		.o_phase (presc_ph)
	);

	// ==========================================================
	// overflow flag events
	assign ovf_set = presc_out && !cnt_wr && s_q.cnt == CNT_MAX;
	assign ovf_clr = wr_ok && i_address == ADDR_STAT && wb[STAT_OVF];

	// next state
	always_comb begin
		s_d = s_q;
		// handshake: one wait cycle, then answer
		case (s_q.st)
			BUS_IDLE: begin
				if (req) begin
					s_d.st = BUS_ACK;
				end
			end
			BUS_ACK: begin
				s_d.st = BUS_IDLE;
			end
			default: begin
				s_d.st = BUS_IDLE;
			end
		endcase
		// read data latched at the first edge, stands at the second
		if (s_q.st == BUS_IDLE && i_read) begin
			case (i_address)
				ADDR_CTRL:   s_d.rdata = {2'h0, s_q.ctl.src, s_q.ctl.async_mode,
					s_q.ctl.ps, s_q.ctl.on};
				ADDR_GATE:   s_d.rdata = {4'h0, s_q.gate.gsel, s_q.gate.gate_active_level,
					s_q.gate.gmode};
				ADDR_OSC:    s_d.rdata = {7'h00, s_q.osc_en};
				ADDR_CNT_LO: s_d.rdata = s_q.cnt[7:0];
				ADDR_CNT_HI: s_d.rdata = s_q.cnt[15:8];
				ADDR_STAT:   s_d.rdata = {7'h00, s_q.ovf};
				ADDR_MASK:   s_d.rdata = {7'h00, s_q.msk};
				default:     s_d.rdata = BYTE_Z;
			endcase
		end
		// register writes
		if (wr_ok) begin
			case (i_address)
				ADDR_CTRL: begin
					s_d.ctl.on         = wb[CTRL_ON];
					s_d.ctl.ps         = wb[CTRL_PS_LSB +: 2];
					s_d.ctl.async_mode = wb[CTRL_ASYNC];
					s_d.ctl.src        = wb[CTRL_SRC_LSB +: 2];
				end
				ADDR_GATE: begin
					s_d.gate.gmode = wb[GATE_MODE];
					s_d.gate.gate_active_level  = wb[GATE_POL];
					s_d.gate.gsel  = wb[GATE_SEL_LSB +: 2];
				end
				ADDR_OSC:  s_d.osc_en = wb[OSC_EN_BIT];
				ADDR_MASK: s_d.msk = wb[STAT_OVF];
				default: begin
				end
			endcase
		end
		// counter: a write wins over an increment in the same cycle
		if (cnt_wr && i_address == ADDR_CNT_LO) begin
			s_d.cnt[7:0] = wb;
		end else if (cnt_wr) begin
			s_d.cnt[15:8] = wb;
		end else if (presc_out) begin
			s_d.cnt = s_q.cnt + 16'h0001;
		end
		// sticky overflow, set wins over clear
		s_d.ovf = (s_q.ovf & ~ovf_clr) | ovf_set;
		// input capture: raw for async, three flops for sync
		s_d.raw_q = src_lvl;
		s_d.sy1   = src_lvl;
		s_d.sy2   = s_q.sy1;
		s_d.sy3   = s_q.sy2;
	end

	// state register
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			s_q    <= '0;
			s_q.st <= BUS_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// oscillator and interrupt outputs
	assign o_osc_running       = s_q.osc_en;
	assign o_crystal_drive_pin = s_q.osc_en & ~i_crystal_input_pin;
	assign o_irq               = s_q.ovf & s_q.msk;
	assign o_wake              = o_irq & i_sleep;

	// ==========================================================
	// checks
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	ovf_set_a: assert property (
		presc_out && !cnt_wr && s_q.cnt == CNT_MAX |=> s_q.ovf && s_q.cnt == CNT_ZERO)
		else $error("overflow did not wrap and set flag");
	cnt_step_a: assert property (
		!cnt_wr && presc_out |=> s_q.cnt == $past(s_q.cnt) + 16'h0001)
		else $error("count did not step by one");
	cnt_still_a: assert property (
		!cnt_wr && !presc_out |=> $stable(s_q.cnt))
		else $error("count moved without a tick");
	gate_hold_a: assert property (
		s_q.gate.gmode && gate_lvl != s_q.gate.gate_active_level |-> !presc_in)
		else $error("gate mismatch let a tick through");
	gate_pass_a: assert property (
		s_q.gate.gmode && gate_lvl == s_q.gate.gate_active_level && run &&
		s_q.ctl.src == SRC_INT |-> presc_in)
		else $error("matching gate blocked counting");
	sleep_hold_a: assert property (
		i_sleep && !(s_q.ctl.async_mode && s_q.ctl.src == SRC_EXT) |-> !presc_in)
		else $error("sleep did not stop synchronous counting");
	async_edge_a: assert property (
		s_q.ctl.async_mode && s_q.ctl.src == SRC_EXT && $rose(i_ext_clk_pin)
		|-> src_tick)
		else $error("async edge not seen in its own cycle");
	sync_edge_a: assert property (
		!s_q.ctl.async_mode && s_q.ctl.src == SRC_EXT && $rose(i_ext_clk_pin)
		##1 !s_q.ctl.async_mode ##1 !s_q.ctl.async_mode |-> src_tick)
		else $error("sync edge not seen after two stages");
	osc_run_a: assert property (
		s_q.osc_en && i_sleep |-> o_osc_running)
		else $error("oscillator stopped in sleep");
	read_cnt_a: assert property (
		s_q.st == BUS_IDLE && i_read && i_address == ADDR_CNT_LO
		|=> o_readdata[7:0] == $past(s_q.cnt[7:0]))
		else $error("count read returned a stale byte");
	irq_wake_a: assert property (
		ovf_set && s_q.msk && i_sleep ##1 i_sleep |-> o_wake)
		else $error("overflow did not raise wake");
	presc_clear_a: assert property (
		cnt_wr |=> presc_ph == '0)
		else $error("count write left prescaler phase");
endmodule : gated_timer

// File: ext_src.sv
// Purpose: external count clock and crystal seen by the timer
// Assumes: both sources far slower than the system clock
// Notes:   crystal line rests at 0 while its oscillator is off
`timescale 1ns/100ps
module ext_src #(
	parameter int EXT_HALF = 3,
	parameter int XTL_HALF = 5
) (
	input  wire logic i_clk,
	input  wire logic i_osc_on,
	output logic      o_ext,
	output logic      o_xtal
);
	// ==========================================================
	// free-running count clock, crystal only while enabled
	int ne = 0;
	int nx = 0;
	initial begin
		o_ext = 1'b0;
		o_xtal = 1'b0;
	end
	always @(posedge i_clk) begin
		ne <= (ne == EXT_HALF - 1) ? 0 : ne + 1;
		nx <= (nx == XTL_HALF - 1) ? 0 : nx + 1;
		if (ne == EXT_HALF - 1)
			o_ext <= ~o_ext;
		if (!i_osc_on)
			o_xtal <= 1'b0; // halted when disabled
		else if (nx == XTL_HALF - 1)
			o_xtal <= ~o_xtal;
	end
endmodule : ext_src

// File: tb.sv
// Purpose: self-checking bench of the gated timer
// Assumes: one wait cycle per bus access
// Notes:   counts checked in windows around the ideal value
`timescale 1ns/100ps
module tb
	import tmr_pkg::*;
;
	// ==========================================================
	// stimulus and observed signals
	logic        i_clk, i_rst_n = 1'b0, i_read = 1'b0, i_write = 1'b0;
	logic [4:0]  i_address = 5'h00;
	logic [31:0] i_writedata = 32'h0, o_readdata;
	logic [3:0]  i_byteenable = 4'hF, i_gate_input_level = 4'h0;
	logic        i_sleep = 1'b0, o_waitrequest, o_irq, o_wake;
	logic        i_ext_clk_pin, i_crystal_input_pin, o_crystal_drive_pin, o_osc_running;
	logic [7:0]  v;
	int          n, cycles = 0, miscompares = 0, checks = 0;

	gated_timer uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_address(i_address),
		.i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
		.i_byteenable(i_byteenable), .o_readdata(o_readdata),
		.o_waitrequest(o_waitrequest), .i_ext_clk_pin(i_ext_clk_pin),
		.i_crystal_input_pin(i_crystal_input_pin),
		.o_crystal_drive_pin(o_crystal_drive_pin),
		.i_gate_input_level(i_gate_input_level), .i_sleep(i_sleep),
		.o_osc_running(o_osc_running), .o_irq(o_irq), .o_wake(o_wake));
	ext_src src (.i_clk(i_clk), .i_osc_on(o_osc_running), .o_ext(i_ext_clk_pin),
		.o_xtal(i_crystal_input_pin));

	// ==========================================================
	// clock and hang guard
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			give_verdict();
		end
	end

	// ==========================================================
	// bus access and compare tasks
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_address <= a;
		i_writedata <= {RD_PAD, d};
		i_write <= 1'b1;
		do @(posedge i_clk); while (o_waitrequest !== 1'b0);
		i_write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		@(posedge i_clk);
		i_address <= a;
		i_read <= 1'b1;
		do @(posedge i_clk); while (o_waitrequest !== 1'b0);
		d = o_readdata[7:0];
		i_read <= 1'b0;
	endtask : rd
	task automatic chk(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
		checks++;
		if ((got >= lo) !== 1'b1 || (got <= hi) !== 1'b1) begin
			miscompares++;
			$display("MISMATCH %0t got %0h want %0h..%0h", $time, got, lo, hi);
		end
	endtask : chk
	// clear count, run 120 cycles with control c, stop, read low byte
	task automatic run_cnt(input logic [7:0] c, output logic [7:0] r);
		wr(ADDR_CTRL, BYTE_Z);
		wr(ADDR_CNT_LO, BYTE_Z);
		wr(ADDR_CNT_HI, BYTE_Z);
		wr(ADDR_CTRL, c);
		repeat (120) @(posedge i_clk);
		wr(ADDR_CTRL, BYTE_Z);
		rd(ADDR_CNT_LO, r);
	endtask : run_cnt
	task automatic give_verdict();
		if (miscompares == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : give_verdict

	// ==========================================================
	// test sequence
	initial begin
		repeat (16) @(posedge i_clk);
		i_rst_n <= 1'b1;
		rd(ADDR_CTRL, v);
		chk(v, 8'h00, 8'h00);
		chk({7'h0, o_osc_running}, 8'h00, 8'h00);
		wr(5'h1C, 8'hFF);
		rd(5'h1C, v);
		chk(v, 8'h00, 8'h00);
		i_byteenable <= 4'h0;
		wr(ADDR_MASK, 8'h01);
		i_byteenable <= 4'hF;
		rd(ADDR_MASK, v);
		chk(v, 8'h00, 8'h00);
		// divide by 1, 2, 4, 8
		for (int p = 0; p < 4; p++) begin
			run_cnt(8'(2 * p + 1), v);
			chk(v, 8'((120 >> p) - 2), 8'((126 >> p) + 1));
		end
		// partial phase must not survive a count write
		wr(ADDR_CTRL, 8'h07);
		repeat (2) @(posedge i_clk);
		wr(ADDR_CTRL, BYTE_Z);
		wr(ADDR_CNT_LO, BYTE_Z);
		wr(ADDR_CTRL, 8'h07);
		repeat (2) @(posedge i_clk);
		rd(ADDR_CNT_LO, v);
		chk(v, 8'h00, 8'h00);
		// gate polarity against level, each source once
		for (int i = 0; i < 4; i++) begin
			i_gate_input_level <= i[1] ? (4'h1 << i) : ~(4'h1 << i);
			wr(ADDR_GATE, {4'h0, i[1:0], i[0], 1'b1});
			run_cnt(8'h01, v);
			if (i[0] == i[1]) chk(v, 8'd118, 8'd127); else chk(v, 8'h00, 8'h00);
		end
		wr(ADDR_GATE, 8'h02);
		run_cnt(8'h01, v);
		chk(v, 8'd118, 8'd127);
		wr(ADDR_GATE, BYTE_Z);
		// external pin, async then sync: rising edges only
		run_cnt(8'h19, v);
		chk(v, 8'd18, 8'd22);
		run_cnt(8'h11, v);
		chk(v, 8'd18, 8'd22);
		// sleep: only async external keeps counting
		i_sleep <= 1'b1;
		run_cnt(8'h19, v);
		chk(v, 8'd18, 8'd22);
		run_cnt(8'h11, v);
		chk(v, 8'h00, 8'h00);
		run_cnt(8'h39, v);
		chk(v, 8'h00, 8'h00);
		wr(ADDR_STAT, 8'h01);
		wr(ADDR_MASK, 8'h01);
		wr(ADDR_CNT_LO, 8'hF0);
		wr(ADDR_CNT_HI, 8'hFF);
		wr(ADDR_CTRL, 8'h19);
		for (n = 0; o_wake !== 1'b1 && n < 200; n++) @(posedge i_clk);
		chk(8'(n), 8'd85, 8'd105);
		wr(ADDR_CTRL, BYTE_Z);
		wr(ADDR_STAT, 8'h01);
		@(posedge i_clk);
		chk({7'h0, o_wake}, 8'h00, 8'h00);
		i_sleep <= 1'b0;
		// secondary oscillator
		run_cnt(8'h21, v);
		chk(v, 8'h00, 8'h00);
		wr(ADDR_OSC, 8'h01);
		run_cnt(8'h21, v);
		chk(v, 8'd10, 8'd14);
		i_sleep <= 1'b1;
		repeat (20) @(posedge i_clk);
		chk({7'h0, o_osc_running}, 8'h01, 8'h01);
		chk({7'h0, o_crystal_drive_pin ^ i_crystal_input_pin}, 8'h01, 8'h01);
		i_sleep <= 1'b0;
		wr(ADDR_OSC, BYTE_Z);
		// start-up wait by FC00 preset, overflow and wrap
		wr(ADDR_STAT, 8'h01);
		wr(ADDR_CNT_LO, BYTE_Z);
		wr(ADDR_CNT_HI, 8'hFC);
		wr(ADDR_CTRL, 8'h01);
		for (n = 0; o_irq !== 1'b1 && n < 1200; n++) @(posedge i_clk);
		chk(8'(n - 1000), 8'd22, 8'd30);
		wr(ADDR_MASK, BYTE_Z);
		@(posedge i_clk);
		chk({7'h0, o_irq}, 8'h00, 8'h00);
		rd(ADDR_STAT, v);
		chk(v, 8'h01, 8'h01);
		rd(ADDR_CNT_HI, v);
		chk(v, 8'h00, 8'h00);
		wr(ADDR_STAT, 8'h01);
		rd(ADDR_STAT, v);
		chk(v, 8'h00, 8'h00);
		give_verdict();
	end
endmodule : tb
